// ==== core/cef_defines.svh ====
/*
 holds the register offsets, field positions and reset values of the can
 fault-flag and buffer-word block.
 assumes it is included by bare name from the package and the modules.
*/
`ifndef CEF_DEFINES_SVH
`define CEF_DEFINES_SVH

// register byte offsets on the apb bus
`define CEF_OFS_FLAGS 12'h000
`define CEF_OFS_WORD2 12'h004

// fault and interrupt flag register fields
`define CEF_FLAG_TX_BUS_OFF 13
`define CEF_FLAG_TX_PASSIVE 12
`define CEF_FLAG_RX_PASSIVE 11
`define CEF_FLAG_TX_WARNING 10
`define CEF_FLAG_RX_WARNING 9
`define CEF_FLAG_ANY_WARNING 8
`define CEF_FLAG_INVALID 7
`define CEF_FLAG_WAKEUP 6
`define CEF_FLAG_ERROR 5
`define CEF_FLAG_QUEUE_FULL 3
`define CEF_FLAG_RX_OVERFLOW 2
`define CEF_FLAG_RX_BUFFER 1
`define CEF_FLAG_TX_BUFFER 0
`define CEF_STATUS_LSB 8
`define CEF_STATUS_W 6
`define CEF_IFLAG_W 8
// implemented interrupt flag bits; bit 4 reads zero
`define CEF_IFLAG_IMPL 8'hEF

// buffer word two fields
`define CEF_W2_EID_LSB 10
`define CEF_W2_EID_W 6
`define CEF_W2_REMOTE 9
`define CEF_W2_RSV1 8
`define CEF_W2_RSV0 4
`define CEF_W2_DLC_LSB 0
`define CEF_W2_DLC_W 4
// writable bits of word two; bits 7-5 read zero
`define CEF_W2_IMPL 16'hFF1F

// reset values
`define CEF_RST_IFLAGS 8'h00
`define CEF_RST_STATUS 6'h00
`define CEF_RST_WORD2 16'h0000

// largest payload of a classic can frame, in bytes
`define CEF_MAX_PAYLOAD 4'h8

`endif

// ==== core/cef_pkg.sv ====
/*
 holds the types shared by the can fault-flag block and its flag bank.
 assumes cef_defines.svh is on the include path.
*/
package cef_pkg;
  `include "cef_defines.svh"

  // fault-confinement state of one side of the node, gray coded
  typedef enum logic [1:0] {
    CEF_ERR_ACTIVE = 2'h0,
    CEF_ERR_PASSIVE = 2'h1,
    CEF_BUS_OFF = 2'h3
  } cef_fault_t;

  typedef logic [15:0] cef_word_t;
endpackage

// ==== core/cef_flag_if.sv ====
/*
 carries event, clear and flag vectors between the top and the flag bank.
 assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
interface cef_flag_if #(parameter int N = 8);
  logic [N-1:0] evt;
  logic [N-1:0] clr;
  logic [N-1:0] flags;
  modport bank (input evt, input clr, output flags);
  modport ctl (output evt, output clr, input flags);
endinterface

// ==== core/cef_flag_bank.sv ====
/*
 holds a bank of sticky interrupt flags, one flip-flop per implemented bit.
 assumes events and clears are single-cycle pulses synchronous to pclk.
*/
`timescale 1ns/1ps
module cef_flag_bank
  import cef_pkg::*;
#(
  parameter int N = 8,
  parameter logic [N-1:0] IMPL = {N{1'b1}}
) (
  input wire logic pclk,
  input wire logic presetn,
  cef_flag_if.bank fb
);

  ////////////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      if (IMPL[i]) begin : g_impl
        logic flag_r;
        logic flag_nxt;
        // set wins over a clear in the same cycle so no event is lost
        assign flag_nxt = fb.evt[i] | (flag_r & ~fb.clr[i]);
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            flag_r <= 1'b0;
          end else begin
            flag_r <= flag_nxt;
          end
        end
        assign fb.flags[i] = flag_r;
      end else begin : g_none
        assign fb.flags[i] = 1'b0;
      end
    end
  endgenerate

endmodule // cef_flag_bank

// ==== core/cef_can_flags.sv ====
/*
 holds the can fault-state status, sticky interrupt flags and message
 buffer word two, reached by software over a zero-wait apb slave.
 assumes the protocol engine drives fault states and one-cycle event
 pulses synchronous to pclk, and that it reads the word two fields.
*/
// Register access over APB and the register addresses were decided locally.
// Overview of operation
// - status bit 13 follows transmitter bus-off state.
// - status bit 12 follows transmitter error-passive state.
// - status bit 11 follows receiver error-passive state.
// - status bit 10 follows transmitter error-warning state.
// - status bit 9 follows receiver error-warning state.
// - status bit 8 is set while either side is in warning.
// - invalid message latches flag bit 7 until cleared.
// - bus activity latches wake-up flag bit 6.
// - any change of status bits 13..8 latches error flag bit 5.
// - receive queue almost full latches flag bit 3.
// - receive buffer overflow latches flag bit 2.
// - flag bits 15-14 and 4 read zero, writes ignored.
// - word two holds extended identifier low bits 15-10, remote bit 9.
// - extended frame with remote bit one is a remote request.
// - standard frame ignores the stored remote bit.
// - word two bits 3-0 hold the data length code.
`timescale 1ns/1ps
`include "cef_defines.svh"
module cef_can_flags
  import cef_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input cef_fault_t tx_fault_state,
  input cef_fault_t rx_fault_state,
  input wire logic tx_warning,
  input wire logic rx_warning,
  input wire logic invalid_msg_evt,
  input wire logic bus_activity_evt,
  input wire logic queue_almost_full_evt,
  input wire logic rx_overflow_evt,
  input wire logic rx_buffer_evt,
  input wire logic tx_buffer_evt,
  input wire logic rx_word_we,
  input wire logic [15:0] rx_word,
  input wire logic frame_ide,
  output logic [5:0] extended_identifier_low_bits,
  output logic remote_frame,
  output logic [1:0] reserved_frame_bits,
  output logic [3:0] data_length_code,
  output logic [3:0] payload_bytes,
  output logic [15:0] fault_and_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic setup_ph;
  logic access_ph;
  logic hit_flags;
  logic hit_word2;
  logic hit_any;
  logic wr_flags;
  logic wr_word2;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_flags = (paddr == `CEF_OFS_FLAGS);
  assign hit_word2 = (paddr == `CEF_OFS_WORD2);
  assign hit_any = hit_flags | hit_word2;
  assign wr_flags = access_ph & pwrite & hit_flags;
  assign wr_word2 = access_ph & pwrite & hit_word2;

  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // fault-state status bits
  logic [5:0] status_r;
  logic [5:0] status_nxt;
  logic tx_off;
  logic tx_passive;
  logic rx_passive;

  assign tx_off = (tx_fault_state == CEF_BUS_OFF);
  assign tx_passive = (tx_fault_state == CEF_ERR_PASSIVE);
  // receiver has no bus-off of its own; anything not active is passive
  assign rx_passive = (rx_fault_state != CEF_ERR_ACTIVE);

  assign status_nxt[`CEF_FLAG_TX_BUS_OFF - `CEF_STATUS_LSB] = tx_off;
  assign status_nxt[`CEF_FLAG_TX_PASSIVE - `CEF_STATUS_LSB] =
    tx_passive;
  assign status_nxt[`CEF_FLAG_RX_PASSIVE - `CEF_STATUS_LSB] =
    rx_passive;
  assign status_nxt[`CEF_FLAG_TX_WARNING - `CEF_STATUS_LSB] =
    tx_warning;
  assign status_nxt[`CEF_FLAG_RX_WARNING - `CEF_STATUS_LSB] =
    rx_warning;
  assign status_nxt[`CEF_FLAG_ANY_WARNING - `CEF_STATUS_LSB] =
    tx_warning | rx_warning;

  // status is read-only: bus writes never reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= `CEF_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt flags
  cef_flag_if #(.N(`CEF_IFLAG_W)) flag_bus ();

  logic status_change;
  logic [7:0] evt_vec;
  logic [7:0] clr_vec;

  // a change of any status bit raises the error flag
  assign status_change = (status_nxt != status_r);

  assign evt_vec[`CEF_FLAG_INVALID] = invalid_msg_evt;
  assign evt_vec[`CEF_FLAG_WAKEUP] = bus_activity_evt;
  assign evt_vec[`CEF_FLAG_ERROR] = status_change;
  assign evt_vec[4] = 1'b0;
  assign evt_vec[`CEF_FLAG_QUEUE_FULL] = queue_almost_full_evt;
  assign evt_vec[`CEF_FLAG_RX_OVERFLOW] = rx_overflow_evt;
  assign evt_vec[`CEF_FLAG_RX_BUFFER] = rx_buffer_evt;
  assign evt_vec[`CEF_FLAG_TX_BUFFER] = tx_buffer_evt;

  // writing zero clears a flag, writing one leaves it alone
  assign clr_vec = {8{wr_flags & pstrb[0]}} & ~pwdata[7:0];

  assign flag_bus.evt = evt_vec;
  assign flag_bus.clr = clr_vec;

  cef_flag_bank #(
    .N(`CEF_IFLAG_W),
    .IMPL(`CEF_IFLAG_IMPL)
  ) u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .fb(flag_bus.bank)
  );

  logic [15:0] flags_word;
  // bits 15-14 are tied low and never written
  assign flags_word = {2'h0, status_r, flag_bus.flags};

  ////////////////////////////////////////////////////////////////////////////
  // message buffer word two
  logic [15:0] word2_r;
  logic [15:0] word2_nxt;
  logic [15:0] bus_word;

  // one write lane per byte strobe; lanes 3 and 2 carry nothing
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_lane
      assign bus_word[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8] :
        word2_r[8*b +: 8];
    end
  endgenerate

  // the receiver loads a whole word and wins over a software write,
  // so a frame that lands mid-access is never half overwritten
  always_comb begin
    word2_nxt = word2_r;
    if (rx_word_we) begin
      word2_nxt = rx_word & `CEF_W2_IMPL;
    end else if (wr_word2) begin
      // reserved bits 8 and 4 are stored as written; software keeps
      // them zero so the frame carries dominant reserved bits
      word2_nxt = bus_word & `CEF_W2_IMPL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word2_r <= `CEF_RST_WORD2;
    end else begin
      word2_r <= word2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame fields towards the protocol engine
  logic [3:0] dlc_w;
  logic [5:0] eid_w;
  logic rtr_w;
  logic [1:0] rsv_w;
  logic [5:0] eid_r;
  logic [5:0] eid_nxt;
  logic remote_r;
  logic remote_nxt;
  logic [1:0] rsv_r;
  logic [1:0] rsv_nxt;
  logic [3:0] dlc_r;
  logic [3:0] dlc_nxt;
  logic [3:0] bytes_r;
  logic [3:0] bytes_nxt;

  assign dlc_w = word2_r[`CEF_W2_DLC_LSB +: `CEF_W2_DLC_W];
  assign eid_w = word2_r[`CEF_W2_EID_LSB +: `CEF_W2_EID_W];
  assign rtr_w = word2_r[`CEF_W2_REMOTE];
  assign rsv_w = {word2_r[`CEF_W2_RSV1], word2_r[`CEF_W2_RSV0]};

  assign eid_nxt = eid_w;
  // remote bit only counts in extended format
  assign remote_nxt = frame_ide & rtr_w;
  assign rsv_nxt = rsv_w;
  assign dlc_nxt = dlc_w;
  // codes above eight still mean an eight-byte payload
  assign bytes_nxt = (dlc_w > `CEF_MAX_PAYLOAD) ? `CEF_MAX_PAYLOAD :
    dlc_w;

  // each field has its own flop so the engine sees one settled copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eid_r <= 6'h00;
    end else begin
      eid_r <= eid_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_r <= 1'b0;
    end else begin
      remote_r <= remote_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsv_r <= 2'h0;
    end else begin
      rsv_r <= rsv_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlc_r <= 4'h0;
    end else begin
      dlc_r <= dlc_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bytes_r <= 4'h0;
    end else begin
      bytes_r <= bytes_nxt;
    end
  end

  assign extended_identifier_low_bits = eid_r;
  assign remote_frame = remote_r;
  assign reserved_frame_bits = rsv_r;
  assign data_length_code = dlc_r;
  assign payload_bytes = bytes_r;

  assign fault_and_flags = flags_word;

  ////////////////////////////////////////////////////////////////////////////
  // read data and error, captured in the setup cycle
  logic [15:0] rd_sel;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  assign rd_sel = hit_flags ? flags_word :
    (hit_word2 ? word2_r : 16'h0000);
  // write cycles read back zero so no register leaks onto the bus
  assign prdata_nxt = pwrite ? 32'h00000000 : {16'h0000, rd_sel};
  assign pslverr_nxt = ~hit_any;

  // snapshot one cycle early keeps pready constant high; a flag set
  // during the access cycle shows on the next read instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup_ph) begin
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

endmodule // cef_can_flags

// ==== tb/cef_can_flags_monitor.sv ====
/*
 checker on the ports of the can fault-flag block.
 assumes engine events are one-cycle pulses synchronous to pclk.
*/
`timescale 1ns/1ps
module cef_can_flags_monitor
  import cef_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input cef_fault_t tx_fault_state,
  input cef_fault_t rx_fault_state,
  input wire logic tx_warning,
  input wire logic rx_warning,
  input wire logic invalid_msg_evt,
  input wire logic bus_activity_evt,
  input wire logic queue_almost_full_evt,
  input wire logic rx_overflow_evt,
  input wire logic frame_ide,
  input wire logic remote_frame,
  input wire logic [15:0] fault_and_flags
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // status lags its inputs by one edge
  property p_bo;
    $past(presetn) |->
      fault_and_flags[13] == ($past(tx_fault_state) == CEF_BUS_OFF);
  endproperty
  a_bo: assert property (p_bo) else $error("bus-off bit");
  property p_tp;
    $past(presetn) |->
      fault_and_flags[12] == ($past(tx_fault_state) == CEF_ERR_PASSIVE);
  endproperty
  a_tp: assert property (p_tp) else $error("tx passive bit");
  property p_rp;
    $past(presetn) |->
      fault_and_flags[11] == ($past(rx_fault_state) != CEF_ERR_ACTIVE);
  endproperty
  a_rp: assert property (p_rp) else $error("rx passive bit");
  property p_war;
    $past(presetn) |-> fault_and_flags[10:8] == {$past(tx_warning),
      $past(rx_warning), $past(tx_warning) | $past(rx_warning)};
  endproperty
  a_war: assert property (p_war) else $error("warning bits");
  property p_iv;
    invalid_msg_evt |=> fault_and_flags[7];
  endproperty
  a_iv: assert property (p_iv) else $error("invalid flag");
  property p_wk;
    bus_activity_evt |=> fault_and_flags[6];
  endproperty
  a_wk: assert property (p_wk) else $error("wake-up flag");
  property p_er;
    $changed(fault_and_flags[13:8]) |-> fault_and_flags[5];
  endproperty
  a_er: assert property (p_er) else $error("error flag");
  property p_qf;
    queue_almost_full_evt |=> fault_and_flags[3];
  endproperty
  a_qf: assert property (p_qf) else $error("queue flag");
  property p_ov;
    rx_overflow_evt |=> fault_and_flags[2];
  endproperty
  a_ov: assert property (p_ov) else $error("overflow flag");
  property p_z;
    fault_and_flags[15:14] == 2'h0 && !fault_and_flags[4];
  endproperty
  a_z: assert property (p_z) else $error("unused bits set");
  property p_rm;
    !$past(frame_ide) |-> !remote_frame;
  endproperty
  a_rm: assert property (p_rm) else $error("remote in std frame");
  c_iv: cover property (invalid_msg_evt);
  c_bo: cover property (fault_and_flags[13]);
  c_rm: cover property (remote_frame);
endmodule // cef_can_flags_monitor
bind cef_can_flags cef_can_flags_monitor u_mon (.pclk, .presetn,
  .tx_fault_state, .rx_fault_state, .tx_warning, .rx_warning,
  .invalid_msg_evt, .bus_activity_evt, .queue_almost_full_evt,
  .rx_overflow_evt, .frame_ide, .remote_frame, .fault_and_flags);

// ==== tb/cef_engine_model.sv ====
/*
 protocol-engine side model: fault states, event pulses, received word.
 assumes its tasks are called just after a rising pclk edge.
*/
`timescale 1ns/1ps
module cef_engine_model
  import cef_pkg::*;
(
  input wire logic pclk,
  output cef_fault_t tx_fault_state,
  output cef_fault_t rx_fault_state,
  output logic tx_warning,
  output logic rx_warning,
  output logic [5:0] evt,
  output logic rx_word_we,
  output logic [15:0] rx_word,
  output logic frame_ide
);
  initial begin
    tx_fault_state = CEF_ERR_ACTIVE;
    rx_fault_state = CEF_ERR_ACTIVE;
    {tx_warning, rx_warning, evt, rx_word_we, rx_word, frame_ide} = '0;
  end
  task set_st(input cef_fault_t t, r, input logic tw, rw);
    @(posedge pclk);
    tx_fault_state <= t;
    rx_fault_state <= r;
    tx_warning <= tw;
    rx_warning <= rw;
  endtask
  task pulse(input int i);
    @(posedge pclk);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt <= '0;
  endtask
  // word carries dlc in 3:0; ide picks extended format
  task load(input logic [15:0] w, input logic ide, we);
    @(posedge pclk);
    rx_word <= w;
    frame_ide <= ide;
    rx_word_we <= we;
    @(posedge pclk);
    rx_word_we <= 1'b0;
    rx_word <= ~w; // stale data must not be reused
  endtask
endmodule // cef_engine_model

// ==== tb/can_error_flags_and_buffer_word_test.sv ====
/*
 self-checking bench for the can fault-flag block over apb.
 assumes zero-wait apb slave; flags at 0x000, word two at 0x004.
*/
`timescale 1ns/1ps
`include "cef_defines.svh"
module can_error_flags_and_buffer_word_test import cef_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, tx_warning, rx_warning, rx_word_we, frame_ide;
  cef_fault_t tx_fault_state, rx_fault_state;
  logic [5:0] evt, extended_identifier_low_bits;
  logic [15:0] rx_word, fault_and_flags;
  logic remote_frame;
  logic [1:0] reserved_frame_bits;
  logic [3:0] data_length_code, payload_bytes;
  logic [32:0] q[$];
  int num_errors = 0, comparisons = 0, cyc = 0;
  cef_fault_t ts[3] = '{CEF_ERR_ACTIVE, CEF_ERR_PASSIVE, CEF_BUS_OFF};
  cef_can_flags u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .tx_fault_state,
    .rx_fault_state, .tx_warning, .rx_warning, .invalid_msg_evt(evt[5]),
    .bus_activity_evt(evt[4]), .queue_almost_full_evt(evt[3]),
    .rx_overflow_evt(evt[2]), .rx_buffer_evt(evt[1]),
    .tx_buffer_evt(evt[0]), .rx_word_we, .rx_word, .frame_ide,
    .extended_identifier_low_bits, .remote_frame, .reserved_frame_bits,
    .data_length_code, .payload_bytes, .fault_and_flags);
  cef_engine_model u_eng (.pclk, .tx_fault_state, .rx_fault_state,
    .tx_warning, .rx_warning, .evt, .rx_word_we, .rx_word, .frame_ide);
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [32:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(0, a, 0);
  endtask
  task end_of_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // read data checked where the slave answers
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata},
      q.pop_front());
    if (cyc == 3000) begin
      num_errors++;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cef_fault_t t, r;
    logic tw, rw;
    logic [5:0] st, pst;
    logic [15:0] w;
    void'($urandom(32'hD478B8F8));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(`CEF_OFS_FLAGS, 0);
    rd(`CEF_OFS_WORD2, 0);
    pst = 0;
    repeat (12) begin
      t = ts[$urandom_range(2)];
      r = ts[$urandom_range(2)];
      tw = 1'($urandom);
      rw = 1'($urandom);
      u_eng.set_st(t, r, tw, rw);
      st = {t == CEF_BUS_OFF, t == CEF_ERR_PASSIVE, r != CEF_ERR_ACTIVE,
        tw, rw, tw | rw};
      repeat (2) @(posedge pclk);
      rd(0, {19'h0, st, 2'h0, st != pst, 5'h0});
      apb(1, `CEF_OFS_FLAGS, 32'hFFFFFF00);
      rd(0, {19'h0, st, 8'h00});
      pst = st;
    end
    u_eng.set_st(CEF_ERR_ACTIVE, CEF_ERR_ACTIVE, 0, 0);
    repeat (2) @(posedge pclk);
    apb(1, `CEF_OFS_FLAGS, 0);
    for (int i = 0; i < 6; i++) u_eng.pulse(i);
    rd(0, 33'h00CF);
    apb(1, `CEF_OFS_FLAGS, 32'h0000FFFF);
    rd(0, 33'h00CF);
    pstrb <= 4'h2;
    apb(1, `CEF_OFS_FLAGS, 0);
    pstrb <= 4'hF;
    rd(0, 33'h00CF);
    apb(1, `CEF_OFS_FLAGS, 0);
    rd(0, 0);
    repeat (6) begin
      w = 16'($urandom);
      w[8] = 0;
      w[4] = 0;
      apb(1, `CEF_OFS_WORD2, {16'h0, w});
      rd(`CEF_OFS_WORD2, w & 16'hFF1F);
      for (int i = 0; i < 2; i++) begin
        u_eng.load(0, i[0], 0);
        repeat (2) @(posedge pclk);
        chk({remote_frame, extended_identifier_low_bits, data_length_code,
          payload_bytes, reserved_frame_bits}, {i[0] & w[9], w[15:10],
          w[3:0], (w[3:0] > 4'h8 ? 4'h8 : w[3:0]), w[8],
          w[4]});
      end
    end
    pstrb <= 4'h1;
    apb(1, `CEF_OFS_WORD2, 0);
    pstrb <= 4'hF;
    rd(`CEF_OFS_WORD2, w & 16'hFF00);
    w = 16'($urandom);
    u_eng.load(w, 1, 1);
    rd(`CEF_OFS_WORD2, w & 16'hFF1F);
    chk({remote_frame, reserved_frame_bits, data_length_code},
      {w[9], w[8], w[4], w[3:0]});
    rd(12'h008, {1'b1, 32'h0});
    end_of_test;
  end
endmodule // can_error_flags_and_buffer_word_test
